// [pin_ctl_map.svh]
// register indices, reset values and timing counts for the port t/s pin control
`ifndef PIN_CTL_MAP_SVH
`define PIN_CTL_MAP_SVH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define PORT_T_PULL_POLARITY_IDX 4'h5
`define PORT_T_ROUTING_SELECT_IDX 4'h7
`define PORT_S_DATA_IDX 4'h8
`define PORT_S_PIN_INPUT_IDX 4'h9
`define PORT_S_DIRECTION_IDX 4'hA
`define PORT_S_DRIVE_STRENGTH_IDX 4'hB
`define PORT_S_PULL_ENABLE_IDX 4'hC
`define PORT_S_PULL_POLARITY_IDX 4'hD

// ********************************************************
// field positions and reset values
// ********************************************************
`define PORT_S_TX_PIN 1
`define PORT_S_RX_PIN 0
`define PORT_T_PULL_POLARITY_RST 8'h00
`define PORT_T_ROUTING_SELECT_RST 5'h00
`define PORT_S_DATA_RST 4'h0
`define PORT_S_DIRECTION_RST 4'h0
`define PORT_S_DRIVE_STRENGTH_RST 4'h0
`define PORT_S_PULL_ENABLE_RST 4'hF
`define PORT_S_PULL_POLARITY_RST 4'h0

// ********************************************************
// timing
// ********************************************************
`define PIN_READ_LAG_CYCLES 2

`endif

// [pin_ctl_pkg.sv]
// types shared by the port t/s pin control modules
`default_nettype none
package pin_ctl_pkg;
  typedef logic [7:0] port_t_vec_t;
  typedef logic [4:0] route_vec_t;
  typedef logic [3:0] port_s_vec_t;
  typedef logic [3:0] reg_index_t;
  typedef logic [31:0] apb_word_t;
endpackage : pin_ctl_pkg
`default_nettype wire

// [port_s_pad_if.sv]
// pad control bundle between the register block and the port s pad logic
`default_nettype none
interface port_s_pad_if;
  import pin_ctl_pkg::*;
  port_s_vec_t data;
  port_s_vec_t dir_eff;
  port_s_vec_t drive;
  port_s_vec_t pull_en;
  port_s_vec_t pull_pol;
  port_s_vec_t od_mode;
  logic txd;
  logic tx_en;
  port_s_vec_t pin_out;
  port_s_vec_t pin_oe;
  port_s_vec_t reduced;
  port_s_vec_t pull_up;
  port_s_vec_t pull_down;
  modport ctl (output data, dir_eff, drive, pull_en, pull_pol, od_mode, txd, tx_en,
               input pin_out, pin_oe, reduced, pull_up, pull_down);
  modport pad (input data, dir_eff, drive, pull_en, pull_pol, od_mode, txd, tx_en,
               output pin_out, pin_oe, reduced, pull_up, pull_down);
endinterface : port_s_pad_if
`default_nettype wire

// [pin_sync2.sv]
// two-stage synchroniser for the four port s pin levels
`default_nettype none
module pin_sync2
  import pin_ctl_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire pin_ctl_pkg::port_s_vec_t pin_async, // raw pin levels
  output var pin_ctl_pkg::port_s_vec_t pin_sync // levels after two flops
);
  port_s_vec_t stage1;
  port_s_vec_t next_stage1;
  port_s_vec_t next_pin_sync;

  // stage1 feeds only stage2
  always_comb begin
    next_stage1 = pin_async;
    next_pin_sync = stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      stage1 <= next_stage1;
      pin_sync <= next_pin_sync;
    end
  end
endmodule : pin_sync2
`default_nettype wire

// [port_s_pad_ctl.sv]
// registered pad controls for the four port s pins
`include "pin_ctl_map.svh"
`default_nettype none
module port_s_pad_ctl
  import pin_ctl_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  port_s_pad_if.pad pads // configuration in, pad controls out
);
  port_s_vec_t next_out;
  port_s_vec_t next_oe;
  port_s_vec_t next_reduced;
  port_s_vec_t next_pull_up;
  port_s_vec_t next_pull_down;
  port_s_vec_t value;
  port_s_vec_t pull_on;

  // ********************************************************
  // pad decode
  // ********************************************************
  always_comb begin
    value = pads.data;
    if (pads.tx_en) begin
      value[`PORT_S_TX_PIN] = pads.txd;
    end
    // open-drain drives low only, high is left floating
    next_out = value & ~pads.od_mode;
    next_oe = pads.dir_eff & ~(pads.od_mode & value);
    next_reduced = pads.drive & pads.dir_eff;
    pull_on = pads.pull_en & (~pads.dir_eff | pads.od_mode);
    next_pull_up = pull_on & ~pads.pull_pol;
    next_pull_down = pull_on & pads.pull_pol & ~pads.dir_eff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pads.pin_out <= 4'h0;
      pads.pin_oe <= 4'h0;
      pads.reduced <= 4'h0;
      pads.pull_up <= 4'h0;
      pads.pull_down <= 4'h0;
    end else begin
      pads.pin_out <= next_out;
      pads.pin_oe <= next_oe;
      pads.reduced <= next_reduced;
      pads.pull_up <= next_pull_up;
      pads.pull_down <= next_pull_down;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking pad_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_s_open_drain: assert property (
    (|$past(pads.od_mode & pads.dir_eff)) |->
      ((pads.pin_out & $past(pads.od_mode)) == 4'h0))
    else $error("open-drain pin drives high");

  a_s_reduced_drive: assert property (
    $past(pads.dir_eff) == 4'h0 |-> pads.reduced == 4'h0)
    else $error("reduced drive on input pin");

  a_s_pull_device: assert property (
    ((pads.pull_up & pads.pull_down) == 4'h0) && ((pads.pull_down & pads.pin_oe) == 4'h0))
    else $error("pull devices conflict");
endmodule : port_s_pad_ctl
`default_nettype wire

// [port_t_s_pin_control.sv]
// port t/s pin control: apb register block, pull, routing and direction logic
//
// Summary of operation
// - port t polarity 0 gives pull-up, 1 pull-down, for enabled input pins.
// - each of five routing bits picks timer at 0, pwm at 1.
// - port s data read gives stored bit for outputs, pin level otherwise.
// - serial transmit forces pin 1 output, serial receive forces pin 0 input.
// - port s input register always reads pin levels; writes do nothing.
// - port s direction bit 0 makes input, 1 output, unless overridden.
// - enabled serial channel overrides its pin; direction bits rule again after.
// - reads may lag a direction change by up to two bus cycles.
// - drive bit 0 full, 1 about one third; ignored on inputs.
// - pull enable acts on inputs and open-drain outputs; pull-ups on after reset.
// - polarity 0 pull-up on input or open-drain, 1 pull-down on inputs only.
// - open-drain mode drives low only; clear means push-pull.
`include "pin_ctl_map.svh"
`default_nettype none
module port_t_s_pin_control
  import pin_ctl_pkg::*;
(
  input wire logic pclk, // bus clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire pin_ctl_pkg::apb_word_t pwdata, // apb write data
  output var pin_ctl_pkg::apb_word_t prdata, // apb read data
  output var logic pready, // apb ready
  output var logic pslverr, // unmapped address
  input wire pin_ctl_pkg::port_t_vec_t port_t_pull_enable, // port t pull enables
  input wire pin_ctl_pkg::port_t_vec_t port_t_dir, // port t effective direction
  output var pin_ctl_pkg::port_t_vec_t port_t_pull_up, // port t pull-up on
  output var pin_ctl_pkg::port_t_vec_t port_t_pull_down, // port t pull-down on
  input wire pin_ctl_pkg::route_vec_t timer_module_out, // timer channel outputs
  input wire pin_ctl_pkg::route_vec_t pwm_out, // pwm channel outputs
  output var pin_ctl_pkg::route_vec_t port_t_route_out, // routed port t outputs
  input wire pin_ctl_pkg::port_s_vec_t port_s_open_drain_mode, // open-drain per pin
  input wire logic serial_interface_tx_en, // serial transmitter enabled
  input wire logic serial_interface_rx_en, // serial receiver enabled
  input wire logic serial_interface_txd, // serial transmit data
  output var logic serial_interface_rxd, // serial receive data
  input wire pin_ctl_pkg::port_s_vec_t port_s_pin_in, // port s pin levels
  output var pin_ctl_pkg::port_s_vec_t port_s_pin_out, // port s output values
  output var pin_ctl_pkg::port_s_vec_t port_s_pin_oe, // port s output enables
  output var pin_ctl_pkg::port_s_vec_t port_s_reduced_drive, // reduced drive on
  output var pin_ctl_pkg::port_s_vec_t port_s_pull_up, // port s pull-up on
  output var pin_ctl_pkg::port_s_vec_t port_s_pull_down // port s pull-down on
);

  // ********************************************************
  // declarations
  // ********************************************************
  port_t_vec_t port_t_pull_polarity;
  route_vec_t port_t_routing_select;
  port_s_vec_t port_s_data;
  port_s_vec_t port_s_direction;
  port_s_vec_t port_s_drive_strength;
  port_s_vec_t port_s_pull_enable;
  port_s_vec_t port_s_pull_polarity;
  port_t_vec_t next_port_t_pull_polarity;
  route_vec_t next_port_t_routing_select;
  port_s_vec_t next_port_s_data;
  port_s_vec_t next_port_s_direction;
  port_s_vec_t next_port_s_drive_strength;
  port_s_vec_t next_port_s_pull_enable;
  port_s_vec_t next_port_s_pull_polarity;
  apb_word_t next_prdata;
  logic next_pready;
  logic next_pslverr;
  port_t_vec_t next_port_t_pull_up;
  port_t_vec_t next_port_t_pull_down;
  route_vec_t next_port_t_route_out;
  port_s_vec_t pin_level;
  port_s_vec_t dir_eff;
  port_s_vec_t read_data_view;
  reg_index_t idx;
  logic setup;
  logic wr_take;

  port_s_pad_if pad_bus ();

  // ********************************************************
  // address decode
  // ********************************************************
  function automatic reg_index_t reg_index(input logic [7:0] addr);
    return addr[5:2];
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[1:0] == 2'h0 && addr[7:6] == 2'h0) begin
      unique case (addr[5:2])
        `PORT_T_PULL_POLARITY_IDX, `PORT_T_ROUTING_SELECT_IDX,
        `PORT_S_DATA_IDX, `PORT_S_PIN_INPUT_IDX, `PORT_S_DIRECTION_IDX,
        `PORT_S_DRIVE_STRENGTH_IDX, `PORT_S_PULL_ENABLE_IDX,
        `PORT_S_PULL_POLARITY_IDX: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction : reg_mapped

  // ********************************************************
  // pin sampling and pad logic
  // ********************************************************
  // two flops on the pin levels; reads lag by their depth
  pin_sync2 u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(port_s_pin_in),
    .pin_sync(pin_level)
  );

  port_s_pad_ctl u_pad_ctl (
    .pclk(pclk),
    .presetn(presetn),
    .pads(pad_bus.pad)
  );

  // serial channels take their pins away from the direction bits
  always_comb begin
    dir_eff = port_s_direction;
    if (serial_interface_tx_en) begin
      dir_eff[`PORT_S_TX_PIN] = 1'b1;
    end
    if (serial_interface_rx_en) begin
      dir_eff[`PORT_S_RX_PIN] = 1'b0;
    end
    read_data_view = (dir_eff & port_s_data) | (~dir_eff & pin_level);
  end

  // configuration to the pad logic
  assign pad_bus.data = port_s_data;
  assign pad_bus.dir_eff = dir_eff;
  assign pad_bus.drive = port_s_drive_strength;
  assign pad_bus.pull_en = port_s_pull_enable;
  assign pad_bus.pull_pol = port_s_pull_polarity;
  assign pad_bus.od_mode = port_s_open_drain_mode;
  assign pad_bus.txd = serial_interface_txd;
  assign pad_bus.tx_en = serial_interface_tx_en;

  // pad controls come straight from flops in the pad logic
  assign port_s_pin_out = pad_bus.pin_out;
  assign port_s_pin_oe = pad_bus.pin_oe;
  assign port_s_reduced_drive = pad_bus.reduced;
  assign port_s_pull_up = pad_bus.pull_up;
  assign port_s_pull_down = pad_bus.pull_down;
  assign serial_interface_rxd = pin_level[`PORT_S_RX_PIN];

  // ********************************************************
  // apb slave and register file
  // ********************************************************
  always_comb begin
    idx = reg_index(paddr);
    setup = psel && !penable;
    wr_take = psel && penable && pready && pwrite && reg_mapped(paddr);
    next_pready = setup;
    next_pslverr = setup && !reg_mapped(paddr);
    next_prdata = prdata;
    next_port_t_pull_polarity = port_t_pull_polarity;
    next_port_t_routing_select = port_t_routing_select;
    next_port_s_data = port_s_data;
    next_port_s_direction = port_s_direction;
    next_port_s_drive_strength = port_s_drive_strength;
    next_port_s_pull_enable = port_s_pull_enable;
    next_port_s_pull_polarity = port_s_pull_polarity;
    // read data is fetched in the setup cycle; upper bits stay zero
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (reg_mapped(paddr) && !pwrite) begin
        unique case (idx)
          `PORT_T_PULL_POLARITY_IDX: next_prdata[7:0] = port_t_pull_polarity;
          `PORT_T_ROUTING_SELECT_IDX: next_prdata[4:0] = port_t_routing_select;
          `PORT_S_DATA_IDX: next_prdata[3:0] = read_data_view;
          `PORT_S_PIN_INPUT_IDX: next_prdata[3:0] = pin_level;
          `PORT_S_DIRECTION_IDX: next_prdata[3:0] = port_s_direction;
          `PORT_S_DRIVE_STRENGTH_IDX: next_prdata[3:0] = port_s_drive_strength;
          `PORT_S_PULL_ENABLE_IDX: next_prdata[3:0] = port_s_pull_enable;
          `PORT_S_PULL_POLARITY_IDX: next_prdata[3:0] = port_s_pull_polarity;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    // writes land at the access edge; the input register takes none
    if (wr_take) begin
      unique case (idx)
        `PORT_T_PULL_POLARITY_IDX: next_port_t_pull_polarity = pwdata[7:0];
        `PORT_T_ROUTING_SELECT_IDX: next_port_t_routing_select = pwdata[4:0];
        `PORT_S_DATA_IDX: next_port_s_data = pwdata[3:0];
        `PORT_S_DIRECTION_IDX: next_port_s_direction = pwdata[3:0];
        `PORT_S_DRIVE_STRENGTH_IDX: next_port_s_drive_strength = pwdata[3:0];
        `PORT_S_PULL_ENABLE_IDX: next_port_s_pull_enable = pwdata[3:0];
        `PORT_S_PULL_POLARITY_IDX: next_port_s_pull_polarity = pwdata[3:0];
        default: next_port_s_data = port_s_data;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      port_t_pull_polarity <= `PORT_T_PULL_POLARITY_RST;
      port_t_routing_select <= `PORT_T_ROUTING_SELECT_RST;
      port_s_data <= `PORT_S_DATA_RST;
      port_s_direction <= `PORT_S_DIRECTION_RST;
      port_s_drive_strength <= `PORT_S_DRIVE_STRENGTH_RST;
      port_s_pull_enable <= `PORT_S_PULL_ENABLE_RST;
      port_s_pull_polarity <= `PORT_S_PULL_POLARITY_RST;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      port_t_pull_polarity <= next_port_t_pull_polarity;
      port_t_routing_select <= next_port_t_routing_select;
      port_s_data <= next_port_s_data;
      port_s_direction <= next_port_s_direction;
      port_s_drive_strength <= next_port_s_drive_strength;
      port_s_pull_enable <= next_port_s_pull_enable;
      port_s_pull_polarity <= next_port_s_pull_polarity;
    end
  end

  // ********************************************************
  // port t pull select and routing
  // ********************************************************
  always_comb begin
    next_port_t_pull_up = port_t_pull_enable & ~port_t_dir & ~port_t_pull_polarity;
    next_port_t_pull_down = port_t_pull_enable & ~port_t_dir & port_t_pull_polarity;
    // routing bit 4 is left to software on four-channel parts
    next_port_t_route_out = (port_t_routing_select & pwm_out) |
                            (~port_t_routing_select & timer_module_out);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_t_pull_up <= 8'h00;
      port_t_pull_down <= 8'h00;
      port_t_route_out <= 5'h00;
    end else begin
      port_t_pull_up <= next_port_t_pull_up;
      port_t_pull_down <= next_port_t_pull_down;
      port_t_route_out <= next_port_t_route_out;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking top_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_data_read_setup;
    psel && !penable && !pwrite && paddr == {2'h0, `PORT_S_DATA_IDX, 2'h0};
  endsequence

  sequence s_pins_steady;
    $stable(port_s_pin_in) [*3];
  endsequence

  a_t_pull_select: assert property (
    port_t_pull_up[0] |-> $past(port_t_pull_enable[0] && !port_t_dir[0] && !port_t_pull_polarity[0]))
    else $error("port t pull-up without enabled input and polarity 0");

  a_t_route_mux: assert property (
    $past(port_t_routing_select[2]) |-> port_t_route_out[2] == $past(pwm_out[2]))
    else $error("routed pin not taken from pwm");

  a_s_data_read: assert property (
    s_data_read_setup ##1 penable |->
      prdata == {28'h0000000, $past(read_data_view)} && pready)
    else $error("port s data read mismatch");

  a_s_pin_lag: assert property (
    s_pins_steady |-> pin_level == port_s_pin_in)
    else $error("pin level not seen after two cycles");

  a_s_tx_forced: assert property (
    $past(serial_interface_tx_en && !port_s_open_drain_mode[1]) |-> port_s_pin_oe[1])
    else $error("transmit pin not driven");

  a_s_rx_forced: assert property (
    $past(serial_interface_rx_en) |-> !port_s_pin_oe[0] ##1 1'b1)
    else $error("receive pin driven");

  a_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
endmodule : port_t_s_pin_control
`default_nettype wire

// [port_s_pin_model.sv]
// far-side model of the four port s pins: outside drivers, pulls and floating lines
`default_nettype none
module port_s_pin_model
  import pin_ctl_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire pin_ctl_pkg::port_s_vec_t pin_out, // value the chip drives
  input wire pin_ctl_pkg::port_s_vec_t pin_oe, // chip drives the pin
  input wire pin_ctl_pkg::port_s_vec_t pull_up, // chip pull-up on
  input wire pin_ctl_pkg::port_s_vec_t pull_down, // chip pull-down on
  input wire pin_ctl_pkg::port_s_vec_t ext_en, // outside driver on
  input wire pin_ctl_pkg::port_s_vec_t ext_val, // outside driver value
  output var pin_ctl_pkg::port_s_vec_t pin_level // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  import pin_ctl_pkg::*;
  port_s_vec_t last = 4'h0; // known start, so a bare line never sits at unknown
  // chip driver wins, then outside driver, then pull; a bare line wanders
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pull_up[i]) pin_level[i] = 1'b1;
      else if (pull_down[i]) pin_level[i] = 1'b0;
      else pin_level[i] = ~last[i];
    end
  end
  // last level, so that a floating line never holds still
  always @(posedge pclk) begin
    last <= pin_level;
  end
endmodule : port_s_pin_model
`default_nettype wire

// [test_port_t_s_pin_control.sv]
// self-checking bench for the port t/s pin control
`include "pin_ctl_map.svh"
`default_nettype none
module test_port_t_s_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_ctl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0] paddr;
  apb_word_t pwdata, prdata, rd_data;
  port_t_vec_t t_pull_en, t_dir, t_up, t_down;
  route_vec_t tmr, pwm, route;
  port_s_vec_t od, pin_lvl, s_out, s_oe, s_red, s_up, s_down, ext_en, ext_val;
  logic tx_en, rx_en, txd, rxd;
  int fail_count, n_checks;

  port_t_s_pin_control dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_t_pull_enable(t_pull_en), .port_t_dir(t_dir), .port_t_pull_up(t_up), .port_t_pull_down(t_down),
    .timer_module_out(tmr), .pwm_out(pwm), .port_t_route_out(route), .port_s_open_drain_mode(od),
    .serial_interface_tx_en(tx_en), .serial_interface_rx_en(rx_en), .serial_interface_txd(txd),
    .serial_interface_rxd(rxd), .port_s_pin_in(pin_lvl), .port_s_pin_out(s_out), .port_s_pin_oe(s_oe),
    .port_s_reduced_drive(s_red), .port_s_pull_up(s_up), .port_s_pull_down(s_down));
  port_s_pin_model pins_u (.pclk(pclk), .pin_out(s_out), .pin_oe(s_oe), .pull_up(s_up), .pull_down(s_down),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_lvl));

  // ********************************************************
  // clock, comparisons and bus tasks
  // ********************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input reg_index_t idx, input apb_word_t wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input reg_index_t idx, input apb_word_t d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input reg_index_t idx, input apb_word_t exp);
    apb(1'b0, idx, 32'h0);
    check(rd_data, exp);
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // hang guard, far beyond the roughly 900 ns the tests need
  initial begin
    #50us;
    fail_count++;
    final_report();
  end

  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {t_pull_en, t_dir, tmr, pwm, od, ext_en, ext_val, tx_en, rx_en, txd} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and idle pins held by the reset pull-ups
    rd(`PORT_S_PULL_ENABLE_IDX, 32'h0000000F);
    rd(`PORT_S_DIRECTION_IDX, 32'h00000000);
    rd(`PORT_S_PIN_INPUT_IDX, 32'h0000000F);
    check(32'(s_up), 32'h0000000F);
    $display("test reset done");
    // upper bits dropped, unmapped slot refused
    wr(`PORT_T_ROUTING_SELECT_IDX, 32'hFFFFFFFF);
    rd(`PORT_T_ROUTING_SELECT_IDX, 32'h0000001F);
    wr(`PORT_S_DIRECTION_IDX, 32'hFFFFFFF0);
    rd(`PORT_S_DIRECTION_IDX, 32'h00000000);
    wr(4'h6, 32'h000000FF);
    check({31'h0, rd_err}, 32'h00000001);
    rd(4'h6, 32'h00000000);
    $display("test widths done");
    // port t pulls and routing
    t_pull_en <= 8'hFF;
    t_dir <= 8'h0F;
    tmr <= 5'h15;
    pwm <= 5'h0A;
    wr(`PORT_T_PULL_POLARITY_IDX, 32'h000000A5);
    wr(`PORT_T_ROUTING_SELECT_IDX, 32'h0000000F);
    repeat (2) @(posedge pclk);
    check(32'(t_up), 32'h00000050);
    check(32'(t_down), 32'h000000A0);
    check(32'(route), 32'h0000001A);
    wr(`PORT_T_ROUTING_SELECT_IDX, 32'h00000000);
    repeat (2) @(posedge pclk);
    check(32'(route), 32'h00000015);
    $display("test port t done");
    // port s: open-drain pin pulled low outside, reads split by direction
    od <= 4'h4;
    ext_en <= 4'hE;
    ext_val <= 4'h8;
    wr(`PORT_S_DATA_IDX, 32'h00000006);
    wr(`PORT_S_DIRECTION_IDX, 32'h00000005);
    wr(`PORT_S_DRIVE_STRENGTH_IDX, 32'h0000000F);
    repeat (4) @(posedge pclk);
    check(32'(s_oe), 32'h00000001);
    check(32'(s_out), 32'h00000002);
    check(32'(s_red), 32'h00000005);
    check(32'(s_up), 32'h0000000E);
    rd(`PORT_S_DATA_IDX, 32'h0000000C);
    wr(`PORT_S_PIN_INPUT_IDX, 32'h0000000F);
    rd(`PORT_S_PIN_INPUT_IDX, 32'h00000008);
    wr(`PORT_S_PULL_POLARITY_IDX, 32'h0000000F);
    repeat (2) @(posedge pclk);
    check(32'(s_up), 32'h00000000);
    check(32'(s_down), 32'h0000000A);
    $display("test port s done");
    // serial channels take pins 1 and 0, then give them back
    od <= 4'h0;
    ext_en <= 4'h1;
    ext_val <= 4'h1;
    tx_en <= 1'b1;
    rx_en <= 1'b1;
    txd <= 1'b1;
    wr(`PORT_S_DATA_IDX, 32'h00000000);
    wr(`PORT_S_DIRECTION_IDX, 32'h00000001);
    repeat (4) @(posedge pclk);
    check(32'(s_oe), 32'h00000002);
    check(32'(s_out), 32'h00000002);
    check(32'(rxd), 32'h00000001);
    check(32'(s_red), 32'h00000002);
    tx_en <= 1'b0;
    rx_en <= 1'b0;
    ext_en <= 4'h0;
    repeat (4) @(posedge pclk);
    check(32'(s_oe), 32'h00000001);
    check(32'(s_out), 32'h00000000);
    $display("test serial done");
    final_report();
  end
endmodule : test_port_t_s_pin_control
`default_nettype wire
